// [rtl/asc_regs.svh]
// Register offsets, field positions, codes and reset values of the scan sequencer.
// Summary of operation
// - Writing 0001H at 24H launches a scan.
// - Range 1F00H fills all 32 result buffers.
// - Range register: end high byte, start low.
// - Results live at 80H to FCH.
// - Zero gain fields select gain one.
// - All-ones gain fields select gain eight.
// - Control 0439H selects auto zero, straight binary.
// - Control 0419H selects the 4.9 V reference.
// - Control 0431H selects the 0.6125 V reference.
// - Control 0401H selects differential field channels.
// - Range and gains persist across scans.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

`define ASC_OFF_CTRL 8'h04
`define ASC_OFF_RANGE 8'h10
`define ASC_OFF_LAUNCH 8'h24
`define ASC_OFF_GAIN_FIRST 8'h40
`define ASC_OFF_GAIN_LAST 8'h4C
`define ASC_OFF_MBOX_FIRST 8'h80
`define ASC_OFF_MBOX_CH3 8'h8C
`define ASC_OFF_MBOX_LAST 8'hFC

`define ASC_LAUNCH_VALUE 16'h0001
`define ASC_RST_CTRL 16'h0000
`define ASC_RST_RANGE 16'h0000
`define ASC_RST_GAIN 16'h0000

`define ASC_FMT_BIT 0
`define ASC_SRC_LSB 3
`define ASC_SRC_MSB 5
`define ASC_RANGE_END_LSB 8
`define ASC_RANGE_START_LSB 0

`define ASC_SRC_DIFF 3'h0
`define ASC_SRC_SINGLE 3'h1
`define ASC_SRC_4V9 3'h3
`define ASC_SRC_1V225 3'h5
`define ASC_SRC_0V6125 3'h6
`define ASC_SRC_AUTOZERO 3'h7

`define ASC_GAIN_X1 2'h0
`define ASC_GAIN_X8 2'h3
`define ASC_GAIN_FIELDS 8

`endif

// [rtl/asc_pkg.sv]
// Types shared by the scan sequencer.
package asc_pkg;

  // Analog front end selection driven toward the multiplexers and amplifier.
  typedef struct packed {
    logic [2:0] source;
    logic [4:0] channel;
    logic [1:0] programmable_gain_amp;
  } asc_front_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_KICK,
    ST_WAIT
  } asc_state_t;

endpackage : asc_pkg

// [rtl/asc_sequencer.sv]
// Scan and calibration sequencer with its memory-mapped register file.
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"

module asc_sequencer #(
  parameter int NUM_CH = 32,
  parameter int DATA_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  output asc_pkg::asc_front_t front,
  output logic adc_start,
  input wire logic adc_done_pin,
  input wire logic [15:0] adc_data_pin,
  output logic busy
);

  // The address map fixes 32 result words of 16 bits.
  if (NUM_CH != 32 || DATA_W != 16)
  begin : g_check
    $error("asc_sequencer serves only 32 channels of 16 bits");
  end

  localparam int CH_W = $clog2(NUM_CH);

  logic [15:0] scan_control;
  logic [15:0] channel_range;
  logic [15:0] gain_select [4];
  logic [DATA_W-1:0] result_buffer [NUM_CH];
  asc_pkg::asc_state_t state;
  asc_pkg::asc_state_t next_state;
  logic [CH_W-1:0] chan;
  logic [CH_W-1:0] next_chan;
  logic done_s1;
  logic done_s2;
  logic done_s3;
  logic [15:0] data_s1;
  logic [15:0] data_s2;

  // Gain code of one channel: eight two-bit fields per gain register.
  function automatic logic [1:0] gain_of(input logic [15:0] regs [4], input logic [CH_W-1:0] n);
    logic [15:0] word;
    logic [2:0] field;
    word = regs[n[CH_W-1:3]];
    field = n[2:0];
    gain_of = word[{field, 1'b0} +: 2];
  endfunction : gain_of

  // Straight binary keeps the count, otherwise the MSB flips to two's complement.
  function automatic logic [DATA_W-1:0] code_of(input logic [15:0] raw, input logic [15:0] ctl);
    code_of = ctl[`ASC_FMT_BIT] ? raw : {~raw[15], raw[14:0]};
  endfunction : code_of

  // Register decode.
  wire wr_ctrl = bus_wr && (bus_addr == `ASC_OFF_CTRL);
  wire wr_range = bus_wr && (bus_addr == `ASC_OFF_RANGE);
  wire wr_launch = bus_wr && (bus_addr == `ASC_OFF_LAUNCH);
  wire hit_gain = (bus_addr >= `ASC_OFF_GAIN_FIRST) && (bus_addr <= `ASC_OFF_GAIN_LAST)
                  && (bus_addr[1:0] == 2'h0);
  wire hit_mbox = (bus_addr >= `ASC_OFF_MBOX_FIRST) && (bus_addr[1:0] == 2'h0);
  wire wr_gain = bus_wr && hit_gain;
  wire [1:0] gain_idx = bus_addr[3:2];
  wire [CH_W-1:0] mbox_idx = bus_addr[CH_W+1:2];
  wire launch_cmd = wr_launch && (bus_wdata == `ASC_LAUNCH_VALUE);
  wire [CH_W-1:0] range_start = channel_range[`ASC_RANGE_START_LSB +: CH_W];
  wire [CH_W-1:0] range_end = channel_range[`ASC_RANGE_END_LSB +: CH_W];

  // Read data selection; launch and unmapped offsets read as zero.
  wire [15:0] rd_mux = (bus_addr == `ASC_OFF_CTRL) ? scan_control :
                       (bus_addr == `ASC_OFF_RANGE) ? channel_range :
                       hit_gain ? gain_select[gain_idx] :
                       hit_mbox ? result_buffer[mbox_idx] : 16'h0000;

  // Sequencer control and events.
  wire done_rise = done_s2 && !done_s3;
  wire store = (state == asc_pkg::ST_WAIT) && done_rise;
  wire last = (chan >= range_end);

  // Front end is steered from the control source field, counter and gains.
  assign front.source = scan_control[`ASC_SRC_MSB:`ASC_SRC_LSB];
  assign front.channel = chan;
  assign front.programmable_gain_amp = gain_of(gain_select, chan);
  assign adc_start = (state == asc_pkg::ST_KICK);
  assign busy = (state != asc_pkg::ST_IDLE);

  // Next state: launch loads the start channel, each result but the last advances upward.
  always_comb
  begin
    next_state = state;
    next_chan = chan;
    unique case (state)
      asc_pkg::ST_IDLE:
      begin
        if (launch_cmd)
        begin
          next_state = asc_pkg::ST_KICK;
          next_chan = range_start;
        end
      end
      asc_pkg::ST_KICK:
      begin
        next_state = asc_pkg::ST_WAIT;
      end
      asc_pkg::ST_WAIT:
      begin
        if (store)
        begin
          next_state = last ? asc_pkg::ST_IDLE : asc_pkg::ST_KICK;
          next_chan = last ? chan : chan + 1'b1;
        end
      end
      // The fourth code of the state register is unused; recover to idle.
      default:
      begin
        next_state = asc_pkg::ST_IDLE;
      end
    endcase
  end

  // Two-flop synchronisers for the converter's done and data pins.
  always_ff @(posedge clk_sys)
  begin
    done_s1 <= adc_done_pin;
    done_s2 <= done_s1;
    done_s3 <= done_s2;
    data_s1 <= adc_data_pin;
    data_s2 <= data_s1;
  end

  // Sequencer registers.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= asc_pkg::ST_IDLE;
      chan <= '0;
    end
    else
    begin
      state <= next_state;
      chan <= next_chan;
    end
  end

  // Setting registers change only on their own writes, never on a scan.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scan_control <= `ASC_RST_CTRL;
      channel_range <= `ASC_RST_RANGE;
      for (int i = 0; i < 4; i++)
      begin
        gain_select[i] <= `ASC_RST_GAIN;
      end
    end
    else
    begin
      if (wr_ctrl)
      begin
        scan_control <= bus_wdata;
      end
      if (wr_range)
      begin
        channel_range <= bus_wdata;
      end
      if (wr_gain)
      begin
        gain_select[gain_idx] <= bus_wdata;
      end
    end
  end

  // Result buffers hold each coded result until that slot converts again.
  always_ff @(posedge clk_sys)
  begin
    if (store)
    begin
      result_buffer[chan] <= code_of(data_s2, scan_control);
    end
  end

  // Registered read port, answering one cycle after the read strobe.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_rdata <= 16'h0000;
      bus_rvalid <= 1'b0;
    end
    else
    begin
      bus_rvalid <= bus_rd;
      bus_rdata <= bus_rd ? rd_mux : bus_rdata;
    end
  end

  // Named steps of a scan.
  sequence seq_launch;
    !busy && launch_cmd;
  endsequence

  sequence seq_kick;
    adc_start ##1 (busy && !adc_start);
  endsequence

  sequence seq_store;
    store && !last;
  endsequence

  a_launch_starts: assert property (@(posedge clk_sys) disable iff (rst)
    seq_launch |=> seq_kick)
    else $error("launch did not start a conversion");

  a_launch_other_value: assert property (@(posedge clk_sys) disable iff (rst)
    (!busy && wr_launch && bus_wdata != `ASC_LAUNCH_VALUE) |=> !busy)
    else $error("launch taken for a value other than one");

  a_first_channel: assert property (@(posedge clk_sys) disable iff (rst)
    seq_launch |=> (chan == $past(range_start)))
    else $error("scan did not begin at the start channel");

  a_scan_ascends: assert property (@(posedge clk_sys) disable iff (rst)
    seq_store |=> (chan == $past(chan) + 1'b1) ##0 adc_start)
    else $error("channel did not advance by one");

  // A host may launch again in the first idle cycle, so the second cycle allows that.
  a_scan_ends: assert property (@(posedge clk_sys) disable iff (rst)
    (store && last) |=> !busy ##1 (!busy || $past(launch_cmd)))
    else $error("scan ran past the end channel");

  a_slot_written: assert property (@(posedge clk_sys) disable iff (rst)
    store |=> (result_buffer[$past(chan)] == code_of($past(data_s2), $past(scan_control))))
    else $error("result not stored in its channel slot");

  a_gain_one: assert property (@(posedge clk_sys) disable iff (rst)
    (gain_select[chan[CH_W-1:3]] == `ASC_RST_GAIN)
      |-> (front.programmable_gain_amp == `ASC_GAIN_X1))
    else $error("zero gain field did not give gain one");

  a_gain_eight: assert property (@(posedge clk_sys) disable iff (rst)
    (gain_select[chan[CH_W-1:3]] == 16'hFFFF)
      |-> (front.programmable_gain_amp == `ASC_GAIN_X8))
    else $error("all-ones gain field did not give gain eight");

  a_autozero_src: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ctrl && bus_wdata == 16'h0439) |=> (front.source == `ASC_SRC_AUTOZERO))
    else $error("auto zero not selected");

  a_ref_4v9_src: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ctrl && bus_wdata == 16'h0419) |=> (front.source == `ASC_SRC_4V9))
    else $error("4.9 V reference not selected");

  a_ref_0v6_src: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ctrl && bus_wdata == 16'h0431) |=> (front.source == `ASC_SRC_0V6125))
    else $error("0.6125 V reference not selected");

  a_diff_src: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ctrl && bus_wdata == 16'h0401) |=> (front.source == `ASC_SRC_DIFF))
    else $error("differential inputs not selected");

  a_range_persists: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_range |=> $stable(channel_range))
    else $error("channel range changed without a write");

  // The control word keeps its source and coding until the host rewrites it.
  a_ctrl_persists: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_ctrl |=> $stable(scan_control))
    else $error("control word changed without a write");

  // Gains survive scans and control changes alike.
  a_gain_persists: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_gain |=> $stable(gain_select[0]) && $stable(gain_select[1])
      && $stable(gain_select[2]) && $stable(gain_select[3]))
    else $error("gain select changed without a write");

  // A range read answers in the next cycle with both channel bytes.
  a_range_read: assert property (@(posedge clk_sys) disable iff (rst)
    (bus_rd && bus_addr == `ASC_OFF_RANGE)
      |=> bus_rvalid && (bus_rdata == $past(channel_range)))
    else $error("range read returned a wrong word");

  // The launch register is write only and reads back as zero.
  a_launch_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (bus_rd && bus_addr == `ASC_OFF_LAUNCH) |=> (bus_rdata == 16'h0000))
    else $error("launch register read back nonzero");

  // Each convert request is a single-cycle pulse.
  a_start_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    adc_start |=> !adc_start)
    else $error("convert request held longer than one cycle");

  // Read data stays put between reads so a slow host still sees it.
  a_rdata_holds: assert property (@(posedge clk_sys) disable iff (rst)
    !bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");

endmodule : asc_sequencer

`default_nettype wire

// [tb/asc_conv_model.sv]
// Behavioural converter that answers each convert request of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module asc_conv_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic adc_start,
  input wire asc_pkg::asc_front_t front,
  output logic adc_done_pin,
  output logic [15:0] adc_data_pin
);
  asc_pkg::asc_front_t pend[$];
  logic [15:0] val;
  // Requests are queued so that one arriving while done is still held is not lost.
  always @(posedge clk_sys)
  begin
    if (adc_start === 1'b1)
      pend.push_back(front);
  end
  // The result is stable from one cycle before done rises until five cycles after, then scrambled.
  initial
  begin
    adc_done_pin = 1'b0;
    adc_data_pin = 16'h5A5A;
    forever
    begin
      @(posedge clk_sys);
      if (pend.size() > 0)
      begin
        val = {pend[0].source, pend[0].programmable_gain_amp, 6'h2A, pend[0].channel};
        pend.delete(0);
        repeat (slow ? 17 : 1) @(posedge clk_sys);
        #1 adc_data_pin = val;
        @(posedge clk_sys);
        #1 adc_done_pin = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 adc_done_pin = 1'b0;
        @(posedge clk_sys);
        #1 adc_data_pin = ~val;
      end
    end
  end
endmodule : asc_conv_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench of the scan sequencer with a converter model.
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"
module tb_top;
  logic clk_sys, rst, bus_wr, bus_rd, bus_rvalid, adc_start, adc_done_pin, busy, slow;
  logic [7:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, adc_data_pin;
  asc_pkg::asc_front_t front;
  int err_total, samples_checked;

  asc_sequencer #(.NUM_CH(32), .DATA_W(16)) dut (.clk_sys(clk_sys), .rst(rst),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .front(front), .adc_start(adc_start),
    .adc_done_pin(adc_done_pin), .adc_data_pin(adc_data_pin), .busy(busy));
  asc_conv_model conv (.clk_sys(clk_sys), .slow(slow), .adc_start(adc_start), .front(front),
    .adc_done_pin(adc_done_pin), .adc_data_pin(adc_data_pin));

  // Clock of 5 ns period.
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_wr = 1'b0;
  endtask : wr

  // The answer is registered, so it is looked at one cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [15:0] want);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_rd = 1'b0;
    chk({15'h0000, bus_rvalid}, 16'h0001);
    chk(bus_rdata, want);
  endtask : rd

  // Expected result word: straight binary when bit 0 is set, else the MSB is flipped.
  function automatic logic [15:0] expv(input logic [2:0] s, input logic [1:0] g,
    input logic [4:0] c, input logic b);
    expv = {s, g, 6'h2A, c} ^ {~b, 15'h0000};
  endfunction : expv

  task automatic scan(input logic [15:0] ctl, input logic [2:0] s, input logic [1:0] g,
    input int f, input int l);
    int n;
    wr(`ASC_OFF_CTRL, ctl);
    repeat (1000) @(posedge clk_sys); // Settling time
    wr(`ASC_OFF_LAUNCH, `ASC_LAUNCH_VALUE);
    chk({15'h0000, busy}, 16'h0001);
    n = 0;
    while (busy !== 1'b0 && n < 5000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk({15'h0000, busy}, 16'h0000);
    for (n = f; n <= l; n++)
      rd(`ASC_OFF_MBOX_FIRST + 8'(n * 4), expv(s, g, 5'(n), ctl[0]));
  endtask : scan

  // Watchdog cuts a hang short.
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    conclude();
  end

  // Main sequence of register accesses and scans.
  initial
  begin
    rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    slow = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd(`ASC_OFF_CTRL, `ASC_RST_CTRL);
    rd(`ASC_OFF_RANGE, `ASC_RST_RANGE);
    rd(`ASC_OFF_GAIN_LAST, `ASC_RST_GAIN);
    rd(8'h30, 16'h0000);
    rd(`ASC_OFF_LAUNCH, 16'h0000);
    wr(`ASC_OFF_RANGE, 16'h1F00);
    for (int i = 0; i < 4; i++)
      wr(`ASC_OFF_GAIN_FIRST + 8'(i * 4), 16'h0000);
    scan(16'h0439, `ASC_SRC_AUTOZERO, `ASC_GAIN_X1, 0, 31);
    rd(`ASC_OFF_RANGE, 16'h1F00);
    slow = 1'b1;
    scan(16'h0419, `ASC_SRC_4V9, `ASC_GAIN_X1, 0, 31);
    slow = 1'b0;
    for (int i = 0; i < 4; i++)
      wr(`ASC_OFF_GAIN_FIRST + 8'(i * 4), 16'hFFFF);
    scan(16'h0431, `ASC_SRC_0V6125, `ASC_GAIN_X8, 0, 31);
    wr(`ASC_OFF_RANGE, 16'h0300);
    scan(16'h0401, `ASC_SRC_DIFF, `ASC_GAIN_X8, 0, 3);
    rd(8'h90, expv(`ASC_SRC_0V6125, `ASC_GAIN_X8, 5'h04, 1'b1));
    wr(`ASC_OFF_LAUNCH, 16'h0002);
    chk({15'h0000, busy}, 16'h0000);
    wr(`ASC_OFF_RANGE, 16'h0101);
    scan(16'h0408, `ASC_SRC_SINGLE, `ASC_GAIN_X8, 1, 1);
    rd(`ASC_OFF_MBOX_LAST, expv(`ASC_SRC_0V6125, `ASC_GAIN_X8, 5'h1F, 1'b1));
    conclude();
  end
endmodule : tb_top
`default_nettype wire
